/* hdl/cix_core.sv */
// The implementer's own choices: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module cix_core #(
    parameter int STACK_DEPTH = cix_pkg::STACK_DEPTH
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // program memory
    output logic [cix_pkg::PC_W-1:0] prog_addr,
    input wire logic [15:0] instr_word,
    // axi4-lite write
    input wire logic [cix_pkg::BUS_AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [cix_pkg::BUS_AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    localparam int SP_W = $clog2(STACK_DEPTH);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic [7:0] dfile_q [512];
    logic [12:0] stack_q [STACK_DEPTH];
    logic [SP_W-1:0] sp_q, sp_d;
    cix_pkg::cix_state_type state_q, state_d;
    logic [12:0] pc_q, pc_d;
    logic [7:0] acc_q, acc_d;
    logic carry_q, carry_d, half_q, half_d, null_q, null_d;
    logic expiry_q, expiry_d, sleep_q, sleep_d, run_q, run_d;
    logic [7:0] wdt_q, wdt_d;
    logic dwe, push;
    logic [8:0] dwaddr;
    logic [7:0] dwdata;

    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    logic exec;
    logic [8:0] op_addr;
    logic [2:0] bsel;
    logic [7:0] lit, fval, opnd, res;
    logic [12:0] jtgt, ret_addr, stack_top;
    logic [8:0] sum9;
    logic [4:0] half5;
    logic skip, wres, zupd;

    assign exec = run_q && (state_q == cix_pkg::ST_EXEC);
    assign op_addr = {instr_word[15:14], instr_word[6:0]};
    assign jtgt = {instr_word[15:14], instr_word[10:0]};
    assign bsel = instr_word[9:7];
    assign lit = instr_word[7:0];
    assign fval = dfile_q[op_addr];
    assign opnd = (instr_word[13:12] == cix_pkg::CLS_LIT) ? lit : fval;
    assign sum9 = {1'b0, acc_q} + {1'b0, opnd};
    assign half5 = {1'b0, acc_q[3:0]} + {1'b0, opnd[3:0]};
    assign ret_addr = 13'(pc_q + 13'h0001);
    assign stack_top = stack_q[SP_W'(sp_q - 1'b1)];

    // ----------------------------------------------------------------
    // bus slave state
    // ----------------------------------------------------------------
    logic aw_got_q, aw_got_d, w_got_q, w_got_d;
    logic [11:0] awaddr_q, awaddr_d;
    logic [31:0] wdata_q, wdata_d;
    logic [3:0] wstrb_q, wstrb_d;
    logic awready_d, wready_d, bvalid_d, arready_d, rvalid_d;
    logic [1:0] bresp_d, rresp_d;
    logic [31:0] rdata_d;
    logic wr_fire, wr_hit, rd_take;
    logic [7:0] rd_dval;

    assign wr_fire = aw_got_q && w_got_q && !s_axi_bvalid;
    assign rd_take = s_axi_arvalid && s_axi_arready;
    assign rd_dval = dfile_q[s_axi_araddr[10:2]];
    assign wr_hit = awaddr_q[cix_pkg::DFILE_SEL_BIT] || awaddr_q == cix_pkg::REG_CTRL
        || awaddr_q == cix_pkg::REG_STATUS || awaddr_q == cix_pkg::REG_ACC
        || awaddr_q == cix_pkg::REG_PC || awaddr_q == cix_pkg::REG_WDT
        || awaddr_q == cix_pkg::REG_STACK;

    always_comb begin
        aw_got_d = aw_got_q;
        w_got_d = w_got_q;
        awaddr_d = awaddr_q;
        wdata_d = wdata_q;
        wstrb_d = wstrb_q;
        bvalid_d = s_axi_bvalid;
        bresp_d = s_axi_bresp;
        rvalid_d = s_axi_rvalid;
        rresp_d = s_axi_rresp;
        rdata_d = s_axi_rdata;
        // address and data are taken independently, in either order
        if (s_axi_awvalid && s_axi_awready) begin
            aw_got_d = 1'b1;
            awaddr_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_got_d = 1'b1;
            wdata_d = s_axi_wdata;
            wstrb_d = s_axi_wstrb;
        end
        if (wr_fire) begin
            aw_got_d = 1'b0;
            w_got_d = 1'b0;
            bvalid_d = 1'b1;
            bresp_d = wr_hit ? cix_pkg::RESP_OKAY : cix_pkg::RESP_SLVERR;
        end else if (s_axi_bvalid && s_axi_bready) begin
            bvalid_d = 1'b0;
        end
        if (rd_take) begin
            rvalid_d = 1'b1;
            rresp_d = cix_pkg::RESP_OKAY;
            rdata_d = 32'h0000_0000;
            if (s_axi_araddr[cix_pkg::DFILE_SEL_BIT]) begin
                rdata_d[7:0] = rd_dval;
            end else begin
                unique case (s_axi_araddr)
                    cix_pkg::REG_CTRL: rdata_d[cix_pkg::CTRL_RUN_BIT] = run_q;
                    cix_pkg::REG_STATUS: begin
                        rdata_d[cix_pkg::ST_CARRY_BIT] = carry_q;
                        rdata_d[cix_pkg::ST_HALF_BIT] = half_q;
                        rdata_d[cix_pkg::ST_NULL_BIT] = null_q;
                        rdata_d[cix_pkg::ST_SLEEP_BIT] = sleep_q;
                        rdata_d[cix_pkg::ST_EXPIRY_BIT] = expiry_q;
                    end
                    cix_pkg::REG_ACC: rdata_d[7:0] = acc_q;
                    cix_pkg::REG_PC: rdata_d[12:0] = pc_q;
                    cix_pkg::REG_WDT: rdata_d[7:0] = wdt_q;
                    cix_pkg::REG_STACK: rdata_d[12:0] = stack_top;
                    default: rresp_d = cix_pkg::RESP_SLVERR;
                endcase
            end
        end else if (s_axi_rvalid && s_axi_rready) begin
            rvalid_d = 1'b0;
        end
        awready_d = !aw_got_d && !bvalid_d;
        wready_d = !w_got_d && !bvalid_d;
        arready_d = !rvalid_d;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            awaddr_q <= 12'h000;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= cix_pkg::RESP_OKAY;
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= cix_pkg::RESP_OKAY;
            s_axi_rdata <= 32'h0000_0000;
        end else begin
            aw_got_q <= aw_got_d;
            w_got_q <= w_got_d;
            awaddr_q <= awaddr_d;
            wdata_q <= wdata_d;
            wstrb_q <= wstrb_d;
            s_axi_awready <= awready_d;
            s_axi_wready <= wready_d;
            s_axi_bvalid <= bvalid_d;
            s_axi_bresp <= bresp_d;
            s_axi_arready <= arready_d;
            s_axi_rvalid <= rvalid_d;
            s_axi_rresp <= rresp_d;
            s_axi_rdata <= rdata_d;
        end
    end

    // ----------------------------------------------------------------
    // execute
    // ----------------------------------------------------------------
    // software may touch core state other than the run bit only while halted, so bus and
    // execute never fight over the same register or file entry
    always_comb begin
        acc_d = acc_q;
        carry_d = carry_q;
        half_d = half_q;
        null_d = null_q;
        pc_d = pc_q;
        state_d = state_q;
        run_d = run_q;
        sp_d = sp_q;
        dwe = 1'b0;
        dwaddr = op_addr;
        dwdata = fval;
        push = 1'b0;
        res = 8'h00;
        wres = 1'b0;
        zupd = 1'b0;
        skip = 1'b0;
        wdt_d = run_q ? 8'(wdt_q + 8'h01) : wdt_q;
        expiry_d = (run_q && wdt_q == 8'hFF) ? 1'b0 : expiry_q;
        sleep_d = sleep_q;
        if (exec) begin
            pc_d = ret_addr;
            unique case (instr_word[13:12])
                cix_pkg::CLS_LIT: begin
                    if (instr_word[15:8] == cix_pkg::OP_ADD_LIT) begin
                        acc_d = sum9[7:0];
                        carry_d = sum9[8];
                        half_d = half5[4];
                        null_d = (sum9[7:0] == 8'h00);
                    end else if (instr_word[15:8] == cix_pkg::OP_AND_LIT) begin
                        acc_d = acc_q & lit;
                        null_d = ((acc_q & lit) == 8'h00);
                    end else if (instr_word[15:8] == cix_pkg::OP_OR_LIT) begin
                        acc_d = acc_q | lit;
                        null_d = ((acc_q | lit) == 8'h00);
                    end else if (instr_word == cix_pkg::WORD_WDT_CLR) begin
                        // clear wins over the timeout in the same cycle
                        wdt_d = cix_pkg::RESET_WDT;
                        expiry_d = 1'b1;
                        sleep_d = 1'b1;
                    end
                end
                cix_pkg::CLS_BRANCH: begin
                    pc_d = jtgt;
                    state_d = cix_pkg::ST_BUBBLE;
                    push = !instr_word[11];
                end
                cix_pkg::CLS_BIT: begin
                    unique case (instr_word[11:10])
                        cix_pkg::BOP_CLR: begin
                            dwe = 1'b1;
                            dwdata = fval & ~(8'h01 << bsel);
                        end
                        cix_pkg::BOP_SET: begin
                            dwe = 1'b1;
                            dwdata = fval | (8'h01 << bsel);
                        end
                        cix_pkg::BOP_SKIP_CLR: skip = !fval[bsel];
                        cix_pkg::BOP_SKIP_SET: skip = fval[bsel];
                    endcase
                end
                cix_pkg::CLS_BYTE: begin
                    wres = 1'b1;
                    zupd = 1'b1;
                    unique case (instr_word[11:8])
                        cix_pkg::OP_ADD_REG: begin
                            res = sum9[7:0];
                            carry_d = sum9[8];
                            half_d = half5[4];
                        end
                        cix_pkg::OP_AND_REG: res = acc_q & fval;
                        cix_pkg::OP_OR_REG: res = acc_q | fval;
                        cix_pkg::OP_COM: res = ~fval;
                        cix_pkg::OP_DEC: res = 8'(fval - 8'h01);
                        cix_pkg::OP_INC: res = 8'(fval + 8'h01);
                        cix_pkg::OP_MOV: res = fval;
                        cix_pkg::OP_DEC_SKIP: begin
                            res = 8'(fval - 8'h01);
                            zupd = 1'b0;
                            skip = (res == 8'h00);
                        end
                        cix_pkg::OP_INC_SKIP: begin
                            res = 8'(fval + 8'h01);
                            zupd = 1'b0;
                            skip = (res == 8'h00);
                        end
                        cix_pkg::OP_CLR: begin
                            wres = 1'b0;
                            zupd = 1'b0;
                            if (instr_word[7]) begin
                                dwe = 1'b1;
                                dwdata = 8'h00;
                                null_d = 1'b1;
                            end else if (instr_word == cix_pkg::WORD_CLR_ACC) begin
                                acc_d = 8'h00;
                                null_d = 1'b1;
                            end
                        end
                        default: begin
                            // words outside the subset run as a no-operation
                            wres = 1'b0;
                            zupd = 1'b0;
                        end
                    endcase
                end
            endcase
            if (wres) begin
                if (instr_word[7]) begin
                    dwe = 1'b1;
                    dwdata = res;
                end else begin
                    acc_d = res;
                end
            end
            if (zupd) begin
                null_d = (res == 8'h00);
            end
            if (skip) begin
                // the following word is never fetched: the bubble is the no-op
                pc_d = 13'(pc_q + 13'h0002);
                state_d = cix_pkg::ST_BUBBLE;
            end
            if (push) begin
                sp_d = SP_W'(sp_q + 1'b1);
            end
        end else if (run_q) begin
            state_d = cix_pkg::ST_EXEC;
        end
        if (wr_fire && wstrb_q[0]) begin
            if (awaddr_q == cix_pkg::REG_CTRL) begin
                run_d = wdata_q[cix_pkg::CTRL_RUN_BIT];
            end else if (!run_q) begin
                if (awaddr_q[cix_pkg::DFILE_SEL_BIT]) begin
                    dwe = 1'b1;
                    dwaddr = awaddr_q[10:2];
                    dwdata = wdata_q[7:0];
                end else if (awaddr_q == cix_pkg::REG_ACC) begin
                    acc_d = wdata_q[7:0];
                end else if (awaddr_q == cix_pkg::REG_STATUS) begin
                    carry_d = wdata_q[cix_pkg::ST_CARRY_BIT];
                    half_d = wdata_q[cix_pkg::ST_HALF_BIT];
                    null_d = wdata_q[cix_pkg::ST_NULL_BIT];
                end else if (awaddr_q == cix_pkg::REG_PC && wstrb_q[1]) begin
                    pc_d = wdata_q[12:0];
                    state_d = cix_pkg::ST_EXEC;
                end
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= cix_pkg::ST_EXEC;
            pc_q <= cix_pkg::RESET_PC;
            acc_q <= cix_pkg::RESET_ACC;
            carry_q <= 1'b0;
            half_q <= 1'b0;
            null_q <= 1'b0;
            expiry_q <= 1'b1;
            sleep_q <= 1'b1;
            run_q <= 1'b0;
            wdt_q <= cix_pkg::RESET_WDT;
            sp_q <= '0;
        end else begin
            state_q <= state_d;
            pc_q <= pc_d;
            acc_q <= acc_d;
            carry_q <= carry_d;
            half_q <= half_d;
            null_q <= null_d;
            expiry_q <= expiry_d;
            sleep_q <= sleep_d;
            run_q <= run_d;
            wdt_q <= wdt_d;
            sp_q <= sp_d;
        end
    end

    // file and stack contents carry no reset, as in a real register file
    always_ff @(posedge aclk) begin
        if (dwe) begin
            dfile_q[dwaddr] <= dwdata;
        end
        if (push) begin
            stack_q[sp_q] <= ret_addr;
        end
    end

    assign prog_addr = pc_q;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    logic is_add_lit, is_and_lit, is_branch, is_bitw, is_clr_reg, is_wdt, is_skipop;
    assign is_add_lit = exec && instr_word[15:8] == cix_pkg::OP_ADD_LIT;
    assign is_and_lit = exec && instr_word[15:8] == cix_pkg::OP_AND_LIT;
    assign is_branch = exec && instr_word[13:12] == cix_pkg::CLS_BRANCH;
    assign is_bitw = exec && instr_word[13:11] == 3'h6;
    assign is_clr_reg = exec && instr_word[13:7] == 7'h03;
    assign is_wdt = exec && instr_word == cix_pkg::WORD_WDT_CLR;
    assign is_skipop = exec && instr_word[13:12] == cix_pkg::CLS_BYTE
        && (instr_word[11:8] == cix_pkg::OP_DEC_SKIP || instr_word[11:8] == cix_pkg::OP_INC_SKIP);

    a_add_lit_sum: assert property (is_add_lit |=> acc_q == 8'($past(acc_q) + $past(lit))
        && carry_q == $past(sum9[8]) && null_q == (acc_q == 8'h00))
        else $error("literal add result or flags wrong");
    a_and_lit_flags: assert property (is_and_lit |=> $stable(carry_q) && $stable(half_q)
        && null_q == (acc_q == 8'h00))
        else $error("literal and touched wrong flags");
    a_byte_dest_acc: assert property (exec && instr_word[13:8] == 6'h07 && !instr_word[7]
        |=> acc_q == 8'($past(acc_q) + $past(fval)))
        else $error("register add with target zero missed accumulator");
    a_bit_write: assert property (is_bitw |=> dfile_q[$past(op_addr)][$past(bsel)] == $past(instr_word[10])
        && $stable(null_q) && $stable(carry_q))
        else $error("bit clear or set wrong");
    a_skip_bubble: assert property (exec && skip |=> state_q == cix_pkg::ST_BUBBLE
        && pc_q == 13'($past(pc_q) + 13'h0002) ##1 state_q == cix_pkg::ST_EXEC || !run_q)
        else $error("skip did not take two cycles");
    a_skip_flags: assert property (is_skipop |=> $stable(null_q) && $stable(carry_q))
        else $error("skip counting op changed flags");
    a_clear_reg: assert property (is_clr_reg |=> null_q && dfile_q[$past(op_addr)] == 8'h00)
        else $error("register clear failed");
    a_wdt_clear: assert property (is_wdt |=> wdt_q == 8'h00 && expiry_q && sleep_q)
        else $error("watchdog clear failed");
    a_jump_pc: assert property (is_branch |=> pc_q == $past(jtgt) && state_q == cix_pkg::ST_BUBBLE)
        else $error("branch target not loaded");
    a_call_push: assert property (is_branch && !instr_word[11]
        |=> stack_top == 13'($past(pc_q) + 13'h0001))
        else $error("call pushed wrong return address");

    c_skip_taken: cover property (exec && skip);
    c_call: cover property (is_branch && !instr_word[11]);
    c_bus_write: cover property (wr_fire);
    c_skip_op_zero: cover property (is_skipop && skip);
endmodule
`default_nettype wire

/* hdl/cix_pkg.sv */
package cix_pkg;
    // ----------------------------------------------------------------
    // widths and stack depth
    // ----------------------------------------------------------------
    localparam int DATA_W = 8;
    localparam int FADDR_W = 9;
    localparam int PC_W = 13;
    localparam int BUS_AW = 12;
    localparam int WDT_W = 8;
    localparam int STACK_DEPTH = 8;

    // ----------------------------------------------------------------
    // register offsets and file select bit
    // ----------------------------------------------------------------
    localparam logic [11:0] REG_CTRL = 12'h000;
    localparam logic [11:0] REG_STATUS = 12'h004;
    localparam logic [11:0] REG_ACC = 12'h008;
    localparam logic [11:0] REG_PC = 12'h00C;
    localparam logic [11:0] REG_WDT = 12'h010;
    localparam logic [11:0] REG_STACK = 12'h014;
    localparam int DFILE_SEL_BIT = 11;

    // ----------------------------------------------------------------
    // field positions and reset values
    // ----------------------------------------------------------------
    localparam int CTRL_RUN_BIT = 0;
    localparam int ST_CARRY_BIT = 0;
    localparam int ST_HALF_BIT = 1;
    localparam int ST_NULL_BIT = 2;
    localparam int ST_SLEEP_BIT = 3;
    localparam int ST_EXPIRY_BIT = 4;
    localparam logic [PC_W-1:0] RESET_PC = 13'h0000;
    localparam logic [DATA_W-1:0] RESET_ACC = 8'h00;
    localparam logic [WDT_W-1:0] RESET_WDT = 8'h00;

    // ----------------------------------------------------------------
    // instruction encodings
    // ----------------------------------------------------------------
    localparam logic [1:0] CLS_BYTE = 2'h0;
    localparam logic [1:0] CLS_LIT = 2'h1;
    localparam logic [1:0] CLS_BRANCH = 2'h2;
    localparam logic [1:0] CLS_BIT = 2'h3;
    localparam logic [7:0] OP_ADD_LIT = 8'h1C;
    localparam logic [7:0] OP_AND_LIT = 8'h1B;
    localparam logic [7:0] OP_OR_LIT = 8'h1A;
    localparam logic [15:0] WORD_CLR_ACC = 16'h0140;
    localparam logic [15:0] WORD_WDT_CLR = 16'h1E04;
    localparam logic [3:0] OP_ADD_REG = 4'h7;
    localparam logic [3:0] OP_AND_REG = 4'h5;
    localparam logic [3:0] OP_OR_REG = 4'h4;
    localparam logic [3:0] OP_CLR = 4'h1;
    localparam logic [3:0] OP_COM = 4'h9;
    localparam logic [3:0] OP_DEC = 4'h3;
    localparam logic [3:0] OP_DEC_SKIP = 4'hB;
    localparam logic [3:0] OP_INC = 4'hA;
    localparam logic [3:0] OP_INC_SKIP = 4'hF;
    localparam logic [3:0] OP_MOV = 4'h8;
    localparam logic [1:0] BOP_CLR = 2'h0;
    localparam logic [1:0] BOP_SET = 2'h1;
    localparam logic [1:0] BOP_SKIP_CLR = 2'h2;
    localparam logic [1:0] BOP_SKIP_SET = 2'h3;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        ST_EXEC = 2'b01,
        ST_BUBBLE = 2'b10
    } cix_state_type;
endpackage

/* dv/cix_rom.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// program memory model
// ----------------------------------------------------------------
module cix_rom (
    // fetch port
    input wire logic [cix_pkg::PC_W-1:0] prog_addr,
    output logic [15:0] instr_word
);
    logic [15:0] mem [0:63];
    // only 64 words decoded: upper address bits alias, short programs only
    initial for (int i = 0; i < 64; i++) mem[i] = 16'h0000;
    assign instr_word = mem[prog_addr[5:0]];
endmodule
`default_nettype wire

/* dv/core_instruction_execute_subset_tb.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// bench
// ----------------------------------------------------------------
module core_instruction_execute_subset_tb;
    logic aclk, aresetn, awv, awr, wv, wr_, bv, br, arv, arr, rv, rr;
    logic [12:0] pa;
    logic [15:0] iw;
    logic [11:0] awa, ara;
    logic [31:0] wd, rdat, got;
    logic [1:0] bresp, rresp, gresp;
    int errors, checks, cycles;
    cix_core i_dut (.aclk(aclk), .aresetn(aresetn), .prog_addr(pa), .instr_word(iw),
        .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wr_), .s_axi_bresp(bresp),
        .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv),
        .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
        .s_axi_rready(rr));
    cix_rom i_rom (.prog_addr(pa), .instr_word(iw));
    initial begin
        aclk = 0;
        forever #5 aclk = ~aclk;
    end
    task results;
        if (errors == 0 && checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errors++;
            results();
        end
    end
    task chk(input string n, input logic [31:0] s, input logic [31:0] e);
        checks++;
        if (s !== e) begin
            errors++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d);
        // one idle edge keeps the last release and this request apart
        @(posedge aclk);
        awa <= a; wd <= d; awv <= 1'b1; wv <= 1'b1; br <= 1'b1;
        do begin
            @(posedge aclk);
            if (awr === 1'b1) awv <= 1'b0;
            if (wr_ === 1'b1) wv <= 1'b0;
        end while (bv !== 1'b1);
        br <= 1'b0;
    endtask
    task rd(input logic [11:0] a);
        @(posedge aclk);
        ara <= a; arv <= 1'b1; rr <= 1'b1;
        do begin
            @(posedge aclk);
            if (arr === 1'b1) arv <= 1'b0;
        end while (rv !== 1'b1);
        got = rdat; gresp = rresp; rr <= 1'b0;
    endtask
    task rchk(input string n, input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
        rd(a);
        chk(n, got & m, e);
    endtask
    // halted preload, then run; each program ends in a jump to itself
    task run(input logic [15:0] p[$], input logic [31:0] fv, input logic [31:0] acc);
        for (int i = 0; i < p.size(); i++) i_rom.mem[i] = p[i];
        wr(12'hA14, fv);
        wr(12'h008, acc);
        wr(12'h004, 32'h0);
        wr(12'h00C, 32'h0);
        wr(12'h000, 32'h1);
        repeat (40) @(posedge aclk);
        wr(12'h000, 32'h0);
    endtask
    task scen_alu;
        run({16'h0140, 16'h1CF8, 16'h4785, 16'h1B5F, 16'h1A03, 16'h4F85, 16'h7785, 16'h2807}, 32'h0F, 32'h5A);
        rchk("acc", 12'h008, 32'hFF, 32'h5B);
        rchk("flags", 12'h004, 32'h7, 32'h3);
        rchk("file", 12'hA14, 32'hFF, 32'h88);
        rchk("pc", 12'h00C, 32'h1FFF, 32'h7);
    endtask
    task scen_skip;
        run({16'h4B85, 16'h1C01, 16'h7805, 16'h1C01, 16'h7C05, 16'h1C01, 16'h2009, 16'h0, 16'h0, 16'h2809},
            32'h01, 32'h10);
        rchk("acc", 12'h008, 32'hFF, 32'h11);
        rchk("flags", 12'h004, 32'h7, 32'h0);
        rchk("file", 12'hA14, 32'hFF, 32'h00);
        rchk("pc", 12'h00C, 32'h1FFF, 32'h9);
        rchk("stack", 12'h014, 32'h1FFF, 32'h7);
        rd(12'h7F0);
        chk("resp", {30'h0, gresp}, 32'h2);
    endtask
    // byte ops into both targets, bit clear, register clears and watchdog clear
    task scen_byte;
        run({16'h4185, 16'h4385, 16'h7105, 16'h4505, 16'h4985, 16'h4405, 16'h4A85, 16'h4705, 16'h1E04,
            16'h0180, 16'h4885, 16'h280B}, 32'hA5, 32'h3C);
        rchk("acc", 12'h008, 32'hFF, 32'h41);
        rchk("flags", 12'h004, 32'h1F, 32'h1A);
        rchk("file", 12'hA14, 32'hFF, 32'h05);
        rchk("file0", 12'h800, 32'hFF, 32'h00);
        rchk("pc", 12'h00C, 32'h1FFF, 32'hB);
        // the clear runs early, so the count stays well below one whole run
        rd(12'h010);
        chk("wdt", {31'h0, got[7:0] < 8'h30}, 32'h1);
    endtask
    initial begin
        aresetn = 0; awv = 0; wv = 0; br = 0; arv = 0; rr = 0;
        awa = 0; ara = 0; wd = 0; errors = 0; checks = 0; cycles = 0;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        scen_alu();
        scen_skip();
        scen_byte();
        results();
    end
endmodule
`default_nettype wire
